// file: rtl/exec_pkg.sv
// constants shared by the compact instruction execution unit
package exec_pkg;

   // ---------------------------------------------------------------
   // instruction encodings (value under mask)
   // ---------------------------------------------------------------
   localparam logic [15:0] CMP_HI_MASK = 16'hFF00; // high-register compare
   localparam logic [15:0] CMP_HI_CODE = 16'h4500;
   localparam logic [15:0] XOR_MASK = 16'hFFC0; // register exclusive-or
   localparam logic [15:0] XOR_CODE = 16'h4040;
   localparam logic [15:0] LDM_MASK = 16'hF800; // load multiple
   localparam logic [15:0] LDM_CODE = 16'hC800;
   localparam logic [15:0] LDW_IMM_MASK = 16'hF800; // word load, immediate offset
   localparam logic [15:0] LDW_IMM_CODE = 16'h6800;
   localparam logic [15:0] LDW_REG_MASK = 16'hFE00; // word load, register offset
   localparam logic [15:0] LDW_REG_CODE = 16'h5800;
   localparam logic [15:0] LDW_PC_MASK = 16'hF800; // word load, pc relative
   localparam logic [15:0] LDW_PC_CODE = 16'h4800;
   localparam logic [15:0] LDW_SP_MASK = 16'hF800; // word load, stack relative
   localparam logic [15:0] LDW_SP_CODE = 16'h9800;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int FIRST_HIGH_BIT = 7; // first_high_select
   localparam int SECOND_HIGH_BIT = 6; // second_high_select
   localparam int OFF5_MSB = 10;
   localparam int OFF5_LSB = 6;
   localparam int OFF8_MSB = 7;
   localparam int RM_LSB = 6; // index_reg of register-offset load
   localparam int RN_LSB = 3; // base / source field
   localparam int RD_LSB = 0; // destination field
   localparam int RD8_LSB = 8; // destination of pc / sp relative loads

   // ---------------------------------------------------------------
   // registers and arithmetic
   // ---------------------------------------------------------------
   localparam logic [3:0] STACK_POINTER_IDX = 4'hD;
   localparam logic [3:0] PROGRAM_COUNTER_IDX = 4'hF;
   localparam logic [31:0] PC_AHEAD = 32'h00000004; // pc reads as own address plus 4
   localparam logic [31:0] WORD_STEP = 32'h00000004;
   localparam logic [1:0] WORD_ALIGNED = 2'h0;
   localparam int LIST_WIDTH = 8;

   // ---------------------------------------------------------------
   // flag positions inside the nzcv word
   // ---------------------------------------------------------------
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_C = 1;
   localparam int FLAG_V = 0;

   // ---------------------------------------------------------------
   // register port map (byte offsets)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_GPR_LAST = 8'h3C; // 16 words of general registers
   localparam logic [7:0] OFS_FLAGS = 8'h40;
   localparam logic [7:0] OFS_CTRL = 8'h44;
   localparam logic [7:0] OFS_STATUS = 8'h48;
   localparam int CTRL_ALIGN_EN = 0; // alignment checking enabled
   localparam int CTRL_CP_PRESENT = 1; // system control coprocessor present
   localparam int STAT_BUSY = 0;
   localparam int STAT_ABORT = 1; // sticky: a load saw a data abort
   localparam int STAT_ALIGN = 2; // sticky: alignment exception raised

endpackage

// file: rtl/flag_unit.sv
// subtract or exclusive-or datapath with its condition flags
`timescale 1ns/10ps
module flag_unit (
   // operands
   input wire logic [31:0] op_a,
   input wire logic [31:0] op_b,
   input wire logic carry_in,
   input wire logic sel_xor,
   // result and flags
   output logic [31:0] result,
   output logic flag_n,
   output logic flag_z,
   output logic flag_c,
   output logic flag_v
);
   logic [32:0] diff; // subtraction with carry out

   // ---------------------------------------------------------------
   // arithmetic
   // ---------------------------------------------------------------
   // a minus b as a plus not b plus one, so bit 32 is not-borrow
   always_comb begin
      diff = {1'b0, op_a} + {1'b0, ~op_b} + 33'h000000001;
      if (sel_xor) begin
         result = op_a ^ op_b;
         flag_c = carry_in;
         flag_v = 1'b0;
      end else begin
         result = diff[31:0];
         flag_c = diff[32];
         flag_v = (op_a[31] != op_b[31]) && (diff[31] != op_a[31]);
      end
      flag_n = result[31];
      flag_z = (result == 32'h00000000);
   end
endmodule

// file: rtl/exec_unit.sv
// execution unit for compare, exclusive-or and word loads
// How it works
// - compare subtracts, sets nzcv, stores nothing
// - high bits pick low/high operand pairings
// - xor writes destination, nz from result, v kept
// - load multiple scans list upward from index 0
// - addresses start at base, step four
// - base written back plus four per register
// - base in list keeps the loaded word
// - abort leaves base at original value
// - load multiple drops low two address bits
// - misaligned word load raises alignment exception
// - immediate load adds four times offset
// - immediate load decoded from opcode 01101
// - register load adds base and index
// - pc load clears bit zero, adds offset
// - stack load adds four times offset to sp
// - second high bit widens source field
// - pc reads as instruction address plus four
`timescale 1ns/10ps
module exec_unit (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // instruction issue
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [31:0] instr_addr,
   output logic instr_ready,
   output logic instr_done,
   output logic exc_abort,
   output logic exc_align,
   output logic [3:0] flags_nzcv,
   // data memory load bus
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   input wire logic mem_abort
);
   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_MULTI} state_t;

   typedef struct packed {
      state_t state; // sequencing state
      logic [15:0][31:0] regs; // general register file
      logic [3:0] flags; // n z c v
      logic [7:0] list; // registers still to load
      logic [31:0] orig_base; // base before load multiple
      logic [2:0] base; // base register index
      logic base_in_list; // base appears in the list
      logic [3:0] count; // registers in the list
      logic [3:0] dest; // single load destination
      logic mem_req; // load request held until answered
      logic [31:0] mem_addr;
      logic ready;
      logic done;
      logic exc_abort;
      logic exc_align;
      logic stk_abort; // sticky status copies
      logic stk_align;
      logic align_en;
      logic cp_present;
      logic [31:0] rdata;
   } core_state_t;

   core_state_t s; // registered state
   core_state_t n; // next state
   logic rst_meta; // reset release synchroniser
   logic rst_sync;
   logic [31:0] pc_view; // program counter as seen by the instruction
   logic [3:0] hi_a; // compare operand indices
   logic [3:0] hi_b;
   logic [31:0] op_a;
   logic [31:0] op_b;
   logic [31:0] alu_res;
   logic f_n;
   logic f_z;
   logic f_c;
   logic f_v;
   logic is_cmp;
   logic is_xor;
   logic is_ldm;
   logic is_ldw;
   logic [31:0] ld_addr; // single load address
   logic [3:0] ld_dest;
   logic [3:0] list_cnt; // set bits in the incoming list
   logic [2:0] low_idx; // lowest pending list entry
   logic check_align;
   logic [31:0] wb_value; // written-back base

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   // asynchronous assert, two-flop release
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // decode and operand selection
   // ---------------------------------------------------------------
   // operands and addresses of the presented instruction
   always_comb begin
      pc_view = instr_addr + exec_pkg::PC_AHEAD;
      is_cmp = (instr_word & exec_pkg::CMP_HI_MASK) == exec_pkg::CMP_HI_CODE;
      is_xor = (instr_word & exec_pkg::XOR_MASK) == exec_pkg::XOR_CODE;
      is_ldm = (instr_word & exec_pkg::LDM_MASK) == exec_pkg::LDM_CODE;
      // high specifiers become the top index bit
      hi_a = {instr_word[exec_pkg::FIRST_HIGH_BIT],
              instr_word[exec_pkg::RD_LSB +: 3]};
      hi_b = {instr_word[exec_pkg::SECOND_HIGH_BIT],
              instr_word[exec_pkg::RN_LSB +: 3]};
      if (is_xor) begin
         hi_a = {1'b0, instr_word[exec_pkg::RD_LSB +: 3]};
         hi_b = {1'b0, instr_word[exec_pkg::RN_LSB +: 3]};
      end
      op_a = (hi_a == exec_pkg::PROGRAM_COUNTER_IDX) ? pc_view : s.regs[hi_a];
      op_b = (hi_b == exec_pkg::PROGRAM_COUNTER_IDX) ? pc_view : s.regs[hi_b];
      // single word loads, one addressing mode each
      is_ldw = 1'b1;
      ld_dest = {1'b0, instr_word[exec_pkg::RD_LSB +: 3]};
      if ((instr_word & exec_pkg::LDW_IMM_MASK) == exec_pkg::LDW_IMM_CODE) begin
         ld_addr = s.regs[instr_word[exec_pkg::RN_LSB +: 3]]
                 + {25'h0000000, instr_word[exec_pkg::OFF5_MSB:exec_pkg::OFF5_LSB], 2'h0};
      end else if ((instr_word & exec_pkg::LDW_REG_MASK) == exec_pkg::LDW_REG_CODE) begin
         ld_addr = s.regs[instr_word[exec_pkg::RN_LSB +: 3]]
                 + s.regs[instr_word[exec_pkg::RM_LSB +: 3]];
      end else if ((instr_word & exec_pkg::LDW_PC_MASK) == exec_pkg::LDW_PC_CODE) begin
         ld_dest = {1'b0, instr_word[exec_pkg::RD8_LSB +: 3]};
         ld_addr = {pc_view[31:1], 1'b0}
                 + {22'h000000, instr_word[exec_pkg::OFF8_MSB:0], 2'h0};
      end else if ((instr_word & exec_pkg::LDW_SP_MASK) == exec_pkg::LDW_SP_CODE) begin
         ld_dest = {1'b0, instr_word[exec_pkg::RD8_LSB +: 3]};
         ld_addr = s.regs[exec_pkg::STACK_POINTER_IDX]
                 + {22'h000000, instr_word[exec_pkg::OFF8_MSB:0], 2'h0};
      end else begin
         is_ldw = 1'b0;
         ld_addr = 32'h00000000;
      end
      // alignment checking only with the control coprocessor present
      check_align = s.align_en && s.cp_present;
   end

   // ---------------------------------------------------------------
   // list scanning
   // ---------------------------------------------------------------
   // population count of the new list, lowest pending entry of the old
   always_comb begin
      list_cnt = 4'h0;
      low_idx = 3'h0;
      for (int i = 0; i < exec_pkg::LIST_WIDTH; i++) begin
         list_cnt = list_cnt + {3'h0, instr_word[i]};
      end
      for (int i = exec_pkg::LIST_WIDTH - 1; i >= 0; i--) begin
         if (s.list[i]) begin
            low_idx = 3'(i);
         end
      end
      wb_value = s.orig_base + {26'h0000000, s.count, 2'h0};
   end

   // ---------------------------------------------------------------
   // compare / exclusive-or datapath
   // ---------------------------------------------------------------
   flag_unit u_flag_unit (
      .op_a(op_a),
      .op_b(op_b),
      .carry_in(s.flags[exec_pkg::FLAG_C]),
      .sel_xor(is_xor),
      .result(alu_res),
      .flag_n(f_n),
      .flag_z(f_z),
      .flag_c(f_c),
      .flag_v(f_v)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      n = s;
      n.done = 1'b0;
      n.exc_abort = 1'b0;
      n.exc_align = 1'b0;
      n.rdata = 32'h00000000;
      // register port read, answered next cycle
      if (reg_rd) begin
         if (reg_addr <= exec_pkg::OFS_GPR_LAST) begin
            n.rdata = s.regs[reg_addr[5:2]];
         end else if (reg_addr == exec_pkg::OFS_FLAGS) begin
            n.rdata = {28'h0000000, s.flags};
         end else if (reg_addr == exec_pkg::OFS_CTRL) begin
            n.rdata = {30'h00000000, s.cp_present, s.align_en};
         end else if (reg_addr == exec_pkg::OFS_STATUS) begin
            n.rdata = {29'h00000000, s.stk_align, s.stk_abort, !s.ready};
         end
      end
      // register port write, instruction results below take priority
      if (reg_wr) begin
         if (reg_addr <= exec_pkg::OFS_GPR_LAST) begin
            n.regs[reg_addr[5:2]] = reg_wdata;
         end else if (reg_addr == exec_pkg::OFS_FLAGS) begin
            n.flags = reg_wdata[3:0];
         end else if (reg_addr == exec_pkg::OFS_CTRL) begin
            n.align_en = reg_wdata[exec_pkg::CTRL_ALIGN_EN];
            n.cp_present = reg_wdata[exec_pkg::CTRL_CP_PRESENT];
         end else if (reg_addr == exec_pkg::OFS_STATUS) begin
            // write one to clear sticky bits
            if (reg_wdata[exec_pkg::STAT_ABORT]) begin
               n.stk_abort = 1'b0;
            end
            if (reg_wdata[exec_pkg::STAT_ALIGN]) begin
               n.stk_align = 1'b0;
            end
         end
      end
      unique case (s.state)
         ST_IDLE: begin
            if (instr_valid) begin
               if (is_cmp) begin
                  // flags only, register file untouched
                  n.flags = {f_n, f_z, f_c, f_v};
                  n.done = 1'b1;
               end else if (is_xor) begin
                  n.regs[hi_a] = alu_res;
                  n.flags = {f_n, f_z, f_c, s.flags[exec_pkg::FLAG_V]};
                  n.done = 1'b1;
               end else if (is_ldm) begin
                  n.base = instr_word[10:8];
                  n.orig_base = s.regs[instr_word[10:8]];
                  n.list = instr_word[7:0];
                  n.count = list_cnt;
                  n.base_in_list = instr_word[instr_word[10:8]];
                  n.mem_addr = {s.regs[instr_word[10:8]][31:2], 2'h0};
                  if (check_align && s.regs[instr_word[10:8]][1:0] != exec_pkg::WORD_ALIGNED) begin
                     n.exc_align = 1'b1;
                     n.done = 1'b1;
                  end else if (list_cnt == 4'h0) begin
                     n.done = 1'b1; // empty list: nothing moves
                  end else begin
                     n.mem_req = 1'b1;
                     n.state = ST_MULTI;
                  end
               end else if (is_ldw) begin
                  n.dest = ld_dest;
                  n.mem_addr = ld_addr;
                  if (check_align && ld_addr[1:0] != exec_pkg::WORD_ALIGNED) begin
                     n.exc_align = 1'b1;
                     n.done = 1'b1;
                  end else begin
                     n.mem_req = 1'b1;
                     n.state = ST_LOAD;
                  end
               end else begin
                  n.done = 1'b1; // not handled here: retire with no effect
               end
            end
         end
         ST_LOAD: begin
            if (mem_abort) begin
               n.exc_abort = 1'b1;
               n.mem_req = 1'b0;
               n.done = 1'b1;
               n.state = ST_IDLE;
            end else if (mem_ack) begin
               n.regs[s.dest] = mem_rdata;
               n.mem_req = 1'b0;
               n.done = 1'b1;
               n.state = ST_IDLE;
            end
         end
         ST_MULTI: begin
            if (mem_abort) begin
               n.regs[s.base] = s.orig_base;
               n.exc_abort = 1'b1;
               n.mem_req = 1'b0;
               n.list = 8'h00;
               n.done = 1'b1;
               n.state = ST_IDLE;
            end else if (mem_ack) begin
               n.regs[low_idx] = mem_rdata;
               n.list[low_idx] = 1'b0;
               n.mem_addr = s.mem_addr + exec_pkg::WORD_STEP;
               if (n.list == 8'h00) begin
                  if (!s.base_in_list) begin
                     n.regs[s.base] = wb_value;
                  end
                  // base in list: loaded word stays
                  n.mem_req = 1'b0;
                  n.done = 1'b1;
                  n.state = ST_IDLE;
               end
            end
         end
      endcase
      // sticky status: a new event wins over a clear
      if (n.exc_abort) begin
         n.stk_abort = 1'b1;
      end
      if (n.exc_align) begin
         n.stk_align = 1'b1;
      end
      n.ready = (n.state == ST_IDLE);
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         s <= '0;
         s.ready <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata = s.rdata;
   assign instr_ready = s.ready;
   assign instr_done = s.done;
   assign exc_abort = s.exc_abort;
   assign exc_align = s.exc_align;
   assign flags_nzcv = s.flags;
   assign mem_req = s.mem_req;
   assign mem_addr = s.mem_addr;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_cmp_no_store: assert property (@(posedge core_clk) disable iff (!rst_sync)
      (s.ready && instr_valid && is_cmp && !reg_wr) |=> $stable(s.regs))
      else $error("compare changed the register file");
   a_cmp_zero_flag: assert property (@(posedge core_clk) disable iff (!rst_sync)
      (s.ready && instr_valid && is_cmp && !reg_wr)
      |=> s.flags[exec_pkg::FLAG_Z] == $past(op_a == op_b))
      else $error("compare zero flag wrong");
   a_cmp_carry_flag: assert property (@(posedge core_clk) disable iff (!rst_sync)
      (s.ready && instr_valid && is_cmp && !reg_wr)
      |=> s.flags[exec_pkg::FLAG_C] == $past(op_a >= op_b))
      else $error("compare carry is not not-borrow");
   a_xor_v_kept: assert property (@(posedge core_clk) disable iff (!rst_sync)
      (s.ready && instr_valid && is_xor && !reg_wr)
      |=> $stable(s.flags[exec_pkg::FLAG_V]) && s.done)
      else $error("exclusive-or touched overflow");
   a_ldm_word_addr: assert property (@(posedge core_clk) disable iff (!rst_sync)
      (s.state == ST_MULTI && s.mem_req) |-> s.mem_addr[1:0] == exec_pkg::WORD_ALIGNED)
      else $error("load multiple address not word aligned");
   a_ldm_addr_step: assert property (@(posedge core_clk) disable iff (!rst_sync)
      (s.state == ST_MULTI && mem_ack && !mem_abort && (s.list & (s.list - 8'h01)) != 8'h00)
      |=> s.mem_req && s.mem_addr == $past(s.mem_addr) + exec_pkg::WORD_STEP)
      else $error("load multiple address did not step by four");
   a_ldm_base_wb: assert property (@(posedge core_clk) disable iff (!rst_sync)
      (s.state == ST_MULTI && mem_ack && !mem_abort && !s.base_in_list && !reg_wr
       && (s.list & (s.list - 8'h01)) == 8'h00)
      |=> s.regs[s.base] == s.orig_base + {26'h0000000, s.count, 2'h0})
      else $error("load multiple base writeback wrong");
   a_abort_base: assert property (@(posedge core_clk) disable iff (!rst_sync)
      (s.state == ST_MULTI && mem_abort && !reg_wr)
      |=> s.exc_abort && s.regs[s.base] == s.orig_base && s.ready)
      else $error("abort left base neither original nor reported");
   a_align_no_req: assert property (@(posedge core_clk) disable iff (!rst_sync)
      s.exc_align |-> !s.mem_req && s.ready && s.done)
      else $error("alignment exception still issued a load");
endmodule

// file: testbench/mem_model.sv
// data memory partner answering word loads on the load bus
`timescale 1ns/10ps
module mem_model #(
   parameter logic [31:0] ABORT_ADDR = 32'h00000308, // this address answers with an abort
   parameter logic [31:0] DATA_KEY = 32'h5A5A5A5A // word returned is address xor key
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // load bus
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic [31:0] mem_rdata,
   output logic mem_ack,
   output logic mem_abort
);
   logic [31:0] data_reg; // word of the latest answer
   logic [1:0] wait_reg; // cycles waited on this beat
   logic slow_reg; // alternates prompt and slow answers
   // off an answer the line shows the inverse, so a stale word never matches
   assign mem_rdata = mem_ack ? data_reg : ~data_reg;
   // answer each held request once, after zero or two extra cycles
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_reg <= 32'h00000000;
         wait_reg <= 2'h0;
         slow_reg <= 1'b0;
         mem_ack <= 1'b0;
         mem_abort <= 1'b0;
      end else begin
         mem_ack <= 1'b0;
         mem_abort <= 1'b0;
         if (mem_req && !mem_ack && !mem_abort) begin
            if (wait_reg == {slow_reg, 1'b0}) begin
               wait_reg <= 2'h0;
               slow_reg <= ~slow_reg;
               data_reg <= mem_addr ^ DATA_KEY;
               mem_abort <= (mem_addr == ABORT_ADDR);
               mem_ack <= (mem_addr != ABORT_ADDR);
            end else begin
               wait_reg <= wait_reg + 2'h1;
            end
         end
      end
   end
endmodule

// file: testbench/compact_isa_compare_logic_load_tb.sv
// self-checking bench for the compact instruction execution unit
`timescale 1ns/10ps
module compact_isa_compare_logic_load_tb;
   localparam logic [31:0] KEY = 32'h5A5A5A5A; // memory answers address xor this
   // row: first reg offset and value, second reg offset and value, op, flags, first reg after
   typedef struct packed {
      logic [7:0] ra; logic [31:0] a; logic [7:0] rb; logic [31:0] b;
      logic [15:0] op; logic [3:0] nzcv; logic [31:0] res;
   } row_t;
   logic core_clk = 1'b0;
   logic rst_b, reg_wr, reg_rd, instr_valid, instr_ready, instr_done, exc_abort, exc_align;
   logic mem_req, mem_ack, mem_abort;
   logic [7:0] reg_addr;
   logic [15:0] instr_word;
   logic [31:0] reg_wdata, reg_rdata, instr_addr, mem_addr, mem_rdata;
   logic [3:0] flags_nzcv;
   logic [1:0] exc; // abort and align seen with done
   int failures = 0;
   int samples_checked = 0;
   // compare and alu rows; no compare names two low registers
   row_t rows [7] = '{
      '{8'h04, 32'h5, 8'h20, 32'h5, 16'h4541, 4'h6, 32'h5},
      '{8'h24, 32'h1, 8'h08, 32'h2, 16'h4591, 4'h8, 32'h1},
      '{8'h28, 32'h80000000, 8'h2C, 32'h1, 16'h45DA, 4'h3, 32'h80000000},
      '{8'h0C, 32'h80000001, 8'h10, 32'h1, 16'h4063, 4'hB, 32'h80000000},
      '{8'h14, 32'h1234, 8'h14, 32'h1234, 16'h406D, 4'h7, 32'h0},
      '{8'h04, 32'h0, 8'h20, 32'h1, 16'h4541, 4'h8, 32'h0},
      '{8'h0C, 32'h0, 8'h10, 32'h0, 16'h4063, 4'h4, 32'h0}};
   // clock at 125 MHz
   always #4 core_clk = ~core_clk;
   exec_unit dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr),
      .instr_ready(instr_ready), .instr_done(instr_done), .exc_abort(exc_abort),
      .exc_align(exc_align), .flags_nzcv(flags_nzcv), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_abort(mem_abort));
   mem_model mem_u (.core_clk(core_clk), .rst_b(rst_b), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_abort(mem_abort));
   // -----------------------------------------------------------------
   // bus tasks and comparison
   // -----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // read strobe, then sample the word standing in the following cycle
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      chk(reg_rdata, exp);
   endtask
   // present one instruction, wait a bounded time for retirement
   task automatic issue(input logic [15:0] op, input logic [31:0] at);
      int n;
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr_word <= op;
      instr_addr <= at;
      @(posedge core_clk);
      instr_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (instr_done !== 1'b1 && n < 200);
      if (n >= 200) failures++;
      exc = {exc_abort, exc_align};
   endtask
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      #60000;
      failures++;
      print_verdict;
   end
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      {rst_b, reg_wr, reg_rd, instr_valid, reg_addr, reg_wdata, instr_word, instr_addr} = '0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk({31'h0, instr_ready}, 32'h1);
      rdchk(exec_pkg::OFS_FLAGS, 32'h0);
      rdchk(8'h80, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].ra, rows[i].a);
         wr(rows[i].rb, rows[i].b);
         issue(rows[i].op, 32'h0);
         chk({30'h0, exc}, 32'h0);
         chk({28'h0, flags_nzcv}, {28'h0, rows[i].nzcv});
         rdchk(exec_pkg::OFS_FLAGS, {28'h0, rows[i].nzcv});
         rdchk(rows[i].ra, rows[i].res);
      end
      wr(8'h04, 32'h100);
      issue(16'h6FCD, 32'h0);
      rdchk(8'h14, 32'h17C ^ KEY);
      wr(8'h08, 32'h20);
      issue(16'h588E, 32'h0);
      rdchk(8'h18, 32'h120 ^ KEY);
      issue(16'h4FFF, 32'h1001);
      rdchk(8'h1C, 32'h1400 ^ KEY);
      wr(8'h34, 32'h200);
      issue(16'h9C02, 32'h0);
      rdchk(8'h10, 32'h208 ^ KEY);
      wr(8'h04, 32'h302);
      issue(16'hC905, 32'h0);
      rdchk(8'h00, 32'h300 ^ KEY);
      rdchk(8'h08, 32'h304 ^ KEY);
      rdchk(8'h04, 32'h30A);
      wr(8'h00, 32'h400);
      issue(16'hC803, 32'h0);
      rdchk(8'h00, 32'h400 ^ KEY);
      rdchk(8'h04, 32'h404 ^ KEY);
      wr(8'h04, 32'h304);
      issue(16'hC90C, 32'h0);
      chk({30'h0, exc}, 32'h2);
      rdchk(8'h04, 32'h304);
      wr(exec_pkg::OFS_CTRL, 32'h3);
      wr(8'h04, 32'h101);
      issue(16'h6FCD, 32'h0);
      chk({30'h0, exc}, 32'h1);
      rdchk(8'h14, 32'h17C ^ KEY);
      wr(8'h04, 32'h308);
      issue(16'h680D, 32'h0);
      chk({30'h0, exc}, 32'h2);
      rdchk(8'h14, 32'h17C ^ KEY);
      rdchk(exec_pkg::OFS_STATUS, 32'h6);
      wr(exec_pkg::OFS_STATUS, 32'h6);
      rdchk(exec_pkg::OFS_STATUS, 32'h0);
      print_verdict;
   end
endmodule
